/* File: src/baud_gen.sv */
// fractional baud tick generator
`timescale 1ns/10ps
module baud_gen
	import serial_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	baud_if.gen b
);
	logic [20:0] acc_q;
	logic [20:0] acc_d;
	logic tick_d;
	// ---------------------------------------------
	// accumulator: one bit per divisor/256 clocks
	// ---------------------------------------------
	always_comb begin
		acc_d = acc_q + 21'h000100;
		tick_d = 1'b0;
		if (!b.run) begin
			acc_d = 21'h000000;
		end else if (acc_d >= {1'b0, b.divisor}) begin
			acc_d = acc_d - {1'b0, b.divisor};
			tick_d = 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc_q <= 21'h000000;
		end else begin
			acc_q <= acc_d;
		end
	end
	// tick straight from the sum: a registered tick would put the receiver a clock late
	assign b.tick = tick_d;
endmodule : baud_gen

/* File: src/baud_if.sv */
// bit-tick carrier between the port and its baud generator
`timescale 1ns/10ps
interface baud_if;
	logic run;
	logic [19:0] divisor;
	logic tick;
	modport gen(input run, input divisor, output tick);
	modport user(output run, output divisor, input tick);
endinterface : baud_if

/* File: src/low_power_serial_port.sv */
// low-power serial port: transmitter, receive parity check, flow control
`timescale 1ns/10ps
// Contract
// - word length select picks 8 or 9 bits
// - parity takes last data position
// - odd select 0 even, 1 odd
// - rx parity mismatch flag, irq, clear
// - idle high; per-direction inversion
// - clear-to-send high stops after current character
// - request-to-send low when receiver ready
// - pin swap exchanges tx and rx
// - holding write starts; lsb or msb first
// - one start, one or two stops
// - enable ack once transmitter can send
// - holding write clears empty flag
// - load into shifter sets empty flag
// - empty flag with enable raises irq
// - write while disabled clears empty flag
// - complete flag when line idle, irq
// - four request outputs provided
// - wakeup only from crystal or oscillator
// - fractional generator covers wide rate range
// - rate is 256*clock over divisor
// - dma request when empty flag sets
module low_power_serial_port
	import serial_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_unit_enable,
	input wire logic i_transmit_enable,
	input wire logic i_receive_enable,
	input wire logic i_word_length_select,
	input wire logic i_parity_enable,
	input wire logic i_parity_odd_select,
	input wire logic i_stop_bit_count,
	input wire logic i_msb_first,
	input wire logic i_tx_polarity_invert,
	input wire logic i_rx_polarity_invert,
	input wire logic i_pin_swap,
	input wire logic i_flow_control_enable,
	input wire logic i_tx_dma_enable,
	input wire logic i_rx_dma_enable,
	input wire logic i_tx_empty_irq_enable,
	input wire logic i_tx_complete_irq_enable,
	input wire logic i_parity_error_irq_enable,
	input wire logic i_wakeup_enable,
	input wire logic [1:0] i_kernel_clock_source,
	input wire logic [19:0] i_baud_divisor,
	input wire logic i_hold_write,
	input wire logic [8:0] i_hold_data,
	input wire logic i_tx_complete_clear,
	input wire logic i_parity_error_clear,
	input wire logic i_rx_data_read,
	input wire logic i_pin_a,
	input wire logic i_pin_b,
	input wire logic i_cts,
	output logic o_pin_a,
	output logic o_pin_a_oe_n,
	output logic o_pin_b,
	output logic o_pin_b_oe_n,
	output logic o_rts,
	output logic o_transmit_enable_ack,
	output logic o_tx_holding_empty,
	output logic o_tx_complete,
	output logic o_parity_error_flag,
	output logic o_rx_not_empty,
	output logic [8:0] o_rx_data,
	output logic o_tx_dma_request,
	output logic o_rx_dma_request,
	output logic o_irq_request,
	output logic o_wakeup_request
);
	baud_if tb_if();
	baud_if rb_if();
	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= {i_cts, i_pin_b, i_pin_a};
			sync2_q <= sync1_q;
		end
	end
	logic cts_s;
	logic rx_line;
	assign cts_s = sync2_q[2];
	// swap picks which pin receives
	assign rx_line = (i_pin_swap ? sync2_q[0] : sync2_q[1]) ^ i_rx_polarity_invert;
	// ---------------------------------------------
	// transmitter
	// ---------------------------------------------
	frame_state_t st_q, st_d;
	logic [8:0] hold_q, hold_d;
	logic hold_full_q, hold_full_d;
	logic [8:0] shift_q, shift_d;
	logic [3:0] cnt_q, cnt_d;
	logic par_q, par_d;
	logic tx_bit_q, tx_bit_d;
	logic tc_q, tc_d;
	logic ack_q, ack_d;
	logic en_q, en_d;
	logic dma_q, dma_d;
	logic tx_on;
	logic [3:0] nbits;
	assign tx_on = i_unit_enable & i_transmit_enable;
	// data bits: 8 or 9, one fewer when parity is on
	assign nbits = (i_word_length_select ? 4'h9 : 4'h8) - {3'h0, i_parity_enable};
	assign tb_if.run = tx_on & (st_q != ST_IDLE);
	assign tb_if.divisor = (i_baud_divisor < DIV_MIN) ? DIV_MIN : i_baud_divisor;
	baud_gen u_tx_baud (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.b(tb_if.gen)
	);
	always_comb begin
		st_d = st_q;
		hold_d = hold_q;
		hold_full_d = hold_full_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		par_d = par_q;
		tx_bit_d = tx_bit_q;
		tc_d = tc_q;
		en_d = tx_on;
		// ack follows enable one cycle later, once the shifter is idle
		ack_d = tx_on & (ack_q | st_q == ST_IDLE);
		dma_d = 1'b0;
		if (i_tx_complete_clear) begin
			tc_d = 1'b0;
		end
		case (st_q)
			ST_IDLE: begin
				tx_bit_d = 1'b1;
				// flow control holds new characters only
				if (tx_on && hold_full_q && !(i_flow_control_enable && cts_s)) begin
					st_d = ST_START;
					shift_d = hold_q;
					par_d = parity_of(hold_q & (i_word_length_select ? 9'h0FF : 9'h07F),
						1'b0, i_parity_odd_select);
					hold_full_d = 1'b0;
					dma_d = i_tx_dma_enable;
					tc_d = 1'b0;
					cnt_d = 4'h0;
					tx_bit_d = 1'b0;
				end
			end
			ST_START: begin
				if (tb_if.tick) begin
					st_d = ST_DATA;
					tx_bit_d = i_msb_first ? shift_q[nbits - 4'h1] : shift_q[0];
					cnt_d = 4'h1;
				end
			end
			ST_DATA: begin
				if (tb_if.tick) begin
					if (cnt_q == nbits) begin
						cnt_d = 4'h0;
						if (i_parity_enable) begin
							st_d = ST_PAR;
							tx_bit_d = par_q;
						end else begin
							st_d = ST_STOP;
							tx_bit_d = 1'b1;
						end
					end else begin
						tx_bit_d = i_msb_first ? shift_q[nbits - 4'h1 - cnt_q] : shift_q[cnt_q];
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			ST_PAR: begin
				if (tb_if.tick) begin
					st_d = ST_STOP;
					tx_bit_d = 1'b1;
					cnt_d = 4'h0;
				end
			end
			default: begin
				if (tb_if.tick) begin
					if (cnt_q == {3'h0, i_stop_bit_count}) begin
						st_d = ST_IDLE;
						if (!hold_full_q) begin
							tc_d = 1'b1;
						end
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
		endcase
		if (!tx_on && st_q != ST_IDLE && !i_unit_enable) begin
			st_d = ST_IDLE;
			tx_bit_d = 1'b1;
		end
		// a write lands last, so a load and a write in one cycle keep the new word
		if (i_hold_write) begin
			hold_d = i_hold_data;
			hold_full_d = 1'b1;
			tc_d = 1'b0;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_q <= ST_IDLE;
			hold_q <= HOLD_RESET;
			hold_full_q <= 1'b0;
			shift_q <= HOLD_RESET;
			cnt_q <= 4'h0;
			par_q <= 1'b0;
			tx_bit_q <= 1'b1;
			tc_q <= 1'b0;
			ack_q <= 1'b0;
			en_q <= 1'b0;
			dma_q <= 1'b0;
		end else begin
			st_q <= st_d;
			hold_q <= hold_d;
			hold_full_q <= hold_full_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			par_q <= par_d;
			tx_bit_q <= tx_bit_d;
			tc_q <= tc_d;
			ack_q <= ack_d;
			en_q <= en_d;
			dma_q <= dma_d;
		end
	end
	// ---------------------------------------------
	// receiver with parity check
	// ---------------------------------------------
	frame_state_t rs_q, rs_d;
	logic [8:0] rsh_q, rsh_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic [8:0] rdat_q, rdat_d;
	logic rxne_q, rxne_d;
	logic pe_q, pe_d;
	logic rdma_q, rdma_d;
	logic rprev_q;
	logic half_q, half_d;
	logic rx_on;
	assign rx_on = i_unit_enable & i_receive_enable;
	assign rb_if.run = rx_on & (rs_q != ST_IDLE);
	// receive ticks come every half bit so samples land mid-bit
	assign rb_if.divisor = {1'b0, tb_if.divisor[19:1]};
	baud_gen u_rx_baud (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.b(rb_if.gen)
	);
	// half flag low marks the mid-bit tick, high the bit-boundary tick
	always_comb begin
		rs_d = rs_q;
		rsh_d = rsh_q;
		rcnt_d = rcnt_q;
		rdat_d = rdat_q;
		rxne_d = rxne_q;
		pe_d = pe_q;
		rdma_d = 1'b0;
		half_d = half_q;
		if (i_rx_data_read) begin
			rxne_d = 1'b0;
		end
		if (i_parity_error_clear) begin
			pe_d = 1'b0;
		end
		case (rs_q)
			ST_IDLE: begin
				if (rx_on && rprev_q && !rx_line) begin
					rs_d = ST_START;
					rcnt_d = 4'h0;
					rsh_d = 9'h000;
					half_d = 1'b0;
				end
			end
			ST_START: begin
				// glitch check mid start bit: a high line there drops the frame
				if (rb_if.tick) begin
					half_d = ~half_q;
					if (!half_q && rx_line) begin
						rs_d = ST_IDLE;
					end else if (half_q) begin
						rs_d = ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (rb_if.tick) begin
					half_d = ~half_q;
					if (!half_q) begin
						rsh_d[rcnt_q] = rx_line;
						rcnt_d = rcnt_q + 4'h1;
						if (rcnt_q == (i_word_length_select ? 4'h8 : 4'h7)) begin
							rs_d = ST_STOP;
						end
					end
				end
			end
			default: begin
				if (rb_if.tick && half_q) begin
					half_d = 1'b0;
				end else if (rb_if.tick) begin
					rs_d = ST_IDLE;
					if (!rxne_q || i_rx_data_read) begin
						rdat_d = rsh_q;
						rxne_d = 1'b1;
						rdma_d = i_rx_dma_enable;
					end
					if (i_parity_enable &&
						(parity_of(rsh_q & (i_word_length_select ? 9'h0FF : 9'h07F), 1'b0,
						i_parity_odd_select) != (i_word_length_select ? rsh_q[8] : rsh_q[7]))) begin
						pe_d = 1'b1;
					end
				end
			end
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rs_q <= ST_IDLE;
			rsh_q <= HOLD_RESET;
			rcnt_q <= 4'h0;
			rdat_q <= HOLD_RESET;
			rxne_q <= 1'b0;
			pe_q <= 1'b0;
			rdma_q <= 1'b0;
			rprev_q <= 1'b1;
			half_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			rsh_q <= rsh_d;
			rcnt_q <= rcnt_d;
			rdat_q <= rdat_d;
			rxne_q <= rxne_d;
			pe_q <= pe_d;
			rdma_q <= rdma_d;
			rprev_q <= rx_line;
			half_q <= half_d;
		end
	end
	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	logic line_out;
	assign line_out = tx_bit_q ^ i_tx_polarity_invert;
	assign o_pin_a = i_pin_swap ? 1'b1 : line_out;
	assign o_pin_b = i_pin_swap ? line_out : 1'b1;
	assign o_pin_a_oe_n = i_pin_swap | ~i_unit_enable;
	assign o_pin_b_oe_n = ~i_pin_swap | ~i_unit_enable;
	assign o_rts = i_flow_control_enable ? ~(rx_on & ~rxne_q) : 1'b0;
	assign o_transmit_enable_ack = ack_q;
	assign o_tx_holding_empty = ~hold_full_q;
	assign o_tx_complete = tc_q;
	assign o_parity_error_flag = pe_q;
	assign o_rx_not_empty = rxne_q;
	assign o_rx_data = rdat_q;
	assign o_tx_dma_request = dma_q;
	assign o_rx_dma_request = rdma_q;
	assign o_irq_request = (i_tx_empty_irq_enable & ~hold_full_q)
		| (i_tx_complete_irq_enable & tc_q)
		| (i_parity_error_irq_enable & pe_q);
	// wake only on a start edge when the kernel source can run in stop
	assign o_wakeup_request = i_wakeup_enable & (rs_q == ST_START) &
		((i_kernel_clock_source == SRC_LOW_XTAL) | (i_kernel_clock_source == SRC_FAST_OSC));
endmodule : low_power_serial_port

/* File: src/serial_pkg.sv */
// constants for the low-power serial port transmitter/receiver
package serial_pkg;
	localparam int CLK_HZ = 20000000;
	localparam logic [19:0] DIV_MIN = 20'h00300;
	localparam int FRAC_SHIFT = 8;
	localparam logic [8:0] HOLD_RESET = 9'h000;
	localparam logic [19:0] DIV_RESET = 20'h00300;
	localparam logic [1:0] SRC_LOW_XTAL = 2'h1;
	localparam logic [1:0] SRC_FAST_OSC = 2'h2;
	localparam logic [3:0] ACC_WIDTH_PAD = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} frame_state_t;
	function automatic logic parity_of(input logic [8:0] d, input logic nine, input logic odd);
		logic p;
		p = ^d[7:0] ^ (nine & d[8]);
		return p ^ odd;
	endfunction : parity_of
endpackage : serial_pkg

/* File: test/far_end.sv */
// remote serial transceiver: captures and sends frames, 3 clocks a bit
`timescale 1ns/10ps
module far_end (
	input wire logic i_clk,
	input wire logic i_line_a,
	input wire logic i_line_b,
	output logic o_rx
);
	initial o_rx = 1'h1;
	// sampling mid-bit keeps us clear of the edge the design launches on
	task automatic recv(input logic sw, input logic inv, input int n, output logic [12:0] f);
		int k;
		k = 0;
		f = '1;
		while (((sw ? i_line_b : i_line_a) ^ inv) && k < 400) begin
			@(negedge i_clk);
			k++;
		end
		for (int i = 0; i < n; i++) begin
			repeat (i == 0 ? 1 : 3) @(negedge i_clk);
			f[i] = (sw ? i_line_b : i_line_a) ^ inv;
		end
	endtask : recv
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			o_rx = f[i];
			repeat (3) @(negedge i_clk);
		end
	endtask : send
endmodule : far_end

/* File: test/serial_port_monitor.sv */
// assertion checker for the serial port transmitter and receiver flags
`timescale 1ns/10ps
module serial_port_monitor (
	input wire logic i_clk, i_rst_n, i_unit_enable, i_transmit_enable, i_receive_enable,
	input wire logic i_tx_polarity_invert, i_pin_swap, i_flow_control_enable, i_cts,
	input wire logic i_tx_dma_enable, i_tx_empty_irq_enable, i_tx_complete_irq_enable,
	input wire logic i_parity_error_irq_enable, i_hold_write, o_pin_a, o_pin_a_oe_n,
	input wire logic o_pin_b_oe_n, o_rts, o_transmit_enable_ack, o_tx_holding_empty,
	input wire logic o_tx_complete, o_parity_error_flag, o_rx_not_empty, o_tx_dma_request,
	input wire logic o_irq_request
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_load;
		$rose(o_tx_holding_empty) && !i_pin_swap && !i_tx_polarity_invert;
	endsequence
	sequence s_start_bit;
		(!o_pin_a && !o_pin_a_oe_n) [*2];
	endsequence
	sequence s_cts_held;
		(i_flow_control_enable && i_cts) [*5];
	endsequence
	a_write_clears_empty: assert property (i_hold_write |=> !o_tx_holding_empty)
		else $error("empty flag kept after write");
	a_load_starts_frame: assert property (s_load |-> s_start_bit)
		else $error("no start bit after load");
	a_cts_holds_load: assert property (s_cts_held |-> !$rose(o_tx_holding_empty))
		else $error("load while clear-to-send high");
	a_dma_on_empty: assert property ($rose(o_tx_holding_empty) && i_tx_dma_enable |-> o_tx_dma_request)
		else $error("no dma request on load");
	a_empty_irq_on: assert property (o_tx_holding_empty && i_tx_empty_irq_enable |-> o_irq_request)
		else $error("empty irq missing");
	a_complete_irq_on: assert property (o_tx_complete && i_tx_complete_irq_enable |-> o_irq_request)
		else $error("complete irq missing");
	a_parity_irq_on: assert property (o_parity_error_flag && i_parity_error_irq_enable |-> o_irq_request)
		else $error("parity irq missing");
	a_complete_needs_empty: assert property (o_tx_complete |-> o_tx_holding_empty)
		else $error("complete while holding full");
	a_ack_follows_enable: assert property (i_transmit_enable && i_unit_enable |=> o_transmit_enable_ack)
		else $error("enable ack missing");
	a_idle_stop_level: assert property (o_tx_complete && !i_pin_swap && $stable(i_pin_swap)
		&& $stable(i_tx_polarity_invert) |-> o_pin_a == !i_tx_polarity_invert)
		else $error("idle line not at stop level");
	a_rts_ready_low: assert property (i_flow_control_enable && i_receive_enable && i_unit_enable
		&& !o_rx_not_empty |-> !o_rts)
		else $error("rts high while ready");
	a_swap_pin_roles: assert property (i_pin_swap && $stable(i_pin_swap) && i_unit_enable
		|-> o_pin_a_oe_n && !o_pin_b_oe_n)
		else $error("pin roles not swapped");
endmodule : serial_port_monitor
bind low_power_serial_port serial_port_monitor u_serial_port_monitor (.*);

/* File: test/tb.sv */
// self-checking bench for the serial port transmitter and receiver
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	localparam logic [15:0] FMT [7] = '{16'h00A5, 16'h91C3, 16'h4055, 16'h7455, 16'hE0F1, 16'h0AB4,
		16'hC8A6};
	logic clk = 1'h0, rst_n = 1'h0, ue = 1'h0, te = 1'h0, re = 1'h1, wl = 1'h0, parity_enable = 1'h0;
	logic odd = 1'h0, stp = 1'h0, msb = 1'h0, inv = 1'h0, sw = 1'h0, fc = 1'h0, tx_dma_enable = 1'h0;
	logic eie = 1'h1, tx_complete_irq_enable = 1'h0, parity_error_irq_enable = 1'h1, wr = 1'h0, tcc = 1'h0, pclr = 1'h0, rd = 1'h0;
	logic cts = 1'h0, wke = 1'h0, wk;
	logic [8:0] hd = 9'h000;
	logic pa, pb, pa_oe_n, pb_oe_n, far_rx, rts, ack, emp, tc, pe, rxne, irq;
	logic [8:0] rxd;
	wire wa = pa_oe_n ? far_rx : pa;
	wire wb = pb_oe_n ? far_rx : pb;
	int miscompares = 0, cmp_count = 0, cyc = 0;
	low_power_serial_port u_low_power_serial_port (
		.i_clk(clk), .i_rst_n(rst_n), .i_unit_enable(ue), .i_transmit_enable(te),
		.i_receive_enable(re), .i_word_length_select(wl), .i_parity_enable(parity_enable),
		.i_parity_odd_select(odd), .i_stop_bit_count(stp), .i_msb_first(msb),
		.i_tx_polarity_invert(inv), .i_rx_polarity_invert(1'h0), .i_pin_swap(sw),
		.i_flow_control_enable(fc), .i_tx_dma_enable(tx_dma_enable), .i_rx_dma_enable(1'h0),
		.i_tx_empty_irq_enable(eie), .i_tx_complete_irq_enable(tx_complete_irq_enable),
		.i_parity_error_irq_enable(parity_error_irq_enable), .i_wakeup_enable(wke),
		.i_kernel_clock_source(2'h1), .i_baud_divisor(20'h00300), .i_hold_write(wr),
		.i_hold_data(hd), .i_tx_complete_clear(tcc), .i_parity_error_clear(pclr),
		.i_rx_data_read(rd), .i_pin_a(wa), .i_pin_b(wb), .i_cts(cts), .o_pin_a(pa),
		.o_pin_a_oe_n(pa_oe_n), .o_pin_b(pb), .o_pin_b_oe_n(pb_oe_n), .o_rts(rts),
		.o_transmit_enable_ack(ack), .o_tx_holding_empty(emp), .o_tx_complete(tc),
		.o_parity_error_flag(pe), .o_rx_not_empty(rxne), .o_rx_data(rxd),
		.o_tx_dma_request(), .o_rx_dma_request(), .o_irq_request(irq), .o_wakeup_request(wk));
	far_end u_far_end (.i_clk(clk), .i_line_a(wa), .i_line_b(wb), .o_rx(far_rx));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	function automatic logic [12:0] ef(input logic [8:0] d);
		logic [12:0] f;
		logic [8:0] x;
		int w;
		int nd;
		w = 8 + wl;
		nd = w - parity_enable;
		x = d;
		if (parity_enable) x[w - 1] = ^(x & ((9'h001 << (w - 1)) - 9'h001)) ^ odd;
		f = '1;
		f[0] = 1'h0;
		// parity is always the last bit before the stop bits, whatever the data order
		for (int i = 0; i < nd; i++) f[1 + i] = msb ? x[nd - 1 - i] : x[i];
		if (parity_enable) f[w] = x[w - 1];
		return f;
	endfunction : ef
	task automatic put(input logic [8:0] d);
		@(negedge clk);
		wr = 1'h1;
		hd = d;
		@(negedge clk);
		wr = 1'h0;
	endtask : put
	task automatic rx_chk(input logic [8:0] d, input logic last);
		logic [12:0] f;
		u_far_end.recv(sw, inv, 10 + wl + stp, f);
		`CHK(f, ef(d))
		if (last) begin
			repeat (3) @(negedge clk);
			`CHK({emp, tc}, 2'h3)
		end else begin
			`CHK({emp, tc}, 2'h0)
		end
	endtask : rx_chk
	task automatic t_fmt;
		for (int i = 0; i < 7; i++) begin
			{wl, parity_enable, odd, stp, msb, inv, sw} = FMT[i][15:9];
			repeat (2) @(negedge clk);
			put(FMT[i][8:0]);
			rx_chk(FMT[i][8:0], 1'h1);
		end
		$display("t_fmt done");
	endtask : t_fmt
	task automatic t_b2b;
		{wl, parity_enable, odd, stp, msb, inv, sw} = 7'h00;
		tx_dma_enable = 1'h1;
		put(9'h03C);
		fork
			rx_chk(9'h03C, 1'h0);
			begin
				@(negedge clk);
				for (int k = 0; k < 20 && !emp; k++) @(negedge clk);
				put(9'h0C3);
			end
		join
		rx_chk(9'h0C3, 1'h1);
		tx_dma_enable = 1'h0;
		$display("t_b2b done");
	endtask : t_b2b
	task automatic t_dis;
		te = 1'h0;
		tx_complete_irq_enable = 1'h1;
		put(9'h05A);
		repeat (8) @(negedge clk);
		`CHK({emp, wa}, 2'h1)
		te = 1'h1;
		rx_chk(9'h05A, 1'h1);
		tcc = 1'h1;
		@(negedge clk);
		tcc = 1'h0;
		`CHK(tc, 1'h0)
		tx_complete_irq_enable = 1'h0;
		$display("t_dis done");
	endtask : t_dis
	task automatic t_cts;
		fc = 1'h1;
		cts = 1'h1;
		put(9'h0E7);
		repeat (30) @(negedge clk);
		`CHK({emp, wa, rts}, 3'h2)
		cts = 1'h0;
		rx_chk(9'h0E7, 1'h1);
		re = 1'h0;
		@(negedge clk);
		`CHK(rts, 1'h1)
		re = 1'h1;
		$display("t_cts done");
	endtask : t_cts
	task automatic t_rxpar;
		parity_enable = 1'h1;
		parity_error_irq_enable = 1'h0;
		eie = 1'h0;
		wke = 1'h1;
		fork
			u_far_end.send(11'h602);
			begin
				repeat (4) @(negedge clk);
				`CHK(wk, 1'h1)
			end
		join
		repeat (4) @(negedge clk);
		`CHK({pe, irq, rxne, rts, wk, rxd}, {5'h16, 9'h001})
		wke = 1'h0;
		parity_error_irq_enable = 1'h1;
		@(negedge clk);
		`CHK(irq, 1'h1)
		pclr = 1'h1;
		rd = 1'h1;
		@(negedge clk);
		pclr = 1'h0;
		rd = 1'h0;
		`CHK({pe, irq, rxne}, 3'h0)
		$display("t_rxpar done");
	endtask : t_rxpar
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		ue = 1'h1;
		@(negedge clk);
		te = 1'h1;
		repeat (3) @(negedge clk);
		`CHK(ack, 1'h1)
		t_fmt();
		t_b2b();
		t_dis();
		t_cts();
		t_rxpar();
		end_sim();
	end
endmodule : tb
